// ### src/seq_bank_cfg.svh
// Purpose: Offsets, reset values and codes for the sequencer parameter bank
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: Definitions only
`ifndef SEQ_BANK_CFG_SVH
`define SEQ_BANK_CFG_SVH
`define OFS_ENABLE 8'h00
`define OFS_RUN_LOCK 8'h04
`define OFS_SCALE_SEL 8'h08
`define OFS_SCALE_VAL 8'h0c
`define OFS_FLASH_CLR 8'h10
`define OFS_STATUS 8'h14
`define OFS_USER_BASE 8'h40
`define OFS_ADDR_W 8
`define RST_ENABLE 16'h0000
`define RST_RUN_LOCK 16'h0000
`define RST_SCALE_SEL 16'h0000
`define RST_SCALE_VAL 16'h0001
`define RST_FLASH_CLR 16'h0000
`define RST_USER 16'h0000
`define MAX_SCALE_SEL 16'h0005
`define MAX_SCALE_VAL 16'h7fff
`define MAX_FLASH_CLR 16'h270f
`define FLASH_CLR_KEY 16'h25e0
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HSIZE_WORD 3'h2
`endif

// ### src/seq_bank_pkg.sv
// Purpose: Types shared by the sequencer parameter bank
// Assumes: Nothing beyond the cfg header
// Notes: Types only
package seq_bank_pkg;
    typedef enum logic [2:0] {scale_off, scale_x1, scale_x0p1, scale_x0p01, scale_x0p001, scale_x0p0001} scale_e;
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic valid;
    } ahb_req_s;
    typedef struct packed {
        logic forward_start;
        logic reverse_start;
        logic decel_stop;
    } start_cmd_s;
endpackage

// ### src/embedded_sequencer_param_bank.sv
// Purpose: Parameter bank for the embedded sequence program of a motor drive
// Assumes: One 20 MHz clock; AHB-Lite slave; zero wait states
// Notes: Registers are 16 bits in the low half of each word
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`include "seq_bank_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module embedded_sequencer_param_bank
#(
    parameter int USER_WORDS = 10,
    parameter int IN_TERMS = 12,
    parameter int OUT_TERMS = 8
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic program_key_run,
    input wire logic motor_running,
    input wire logic forward_start_input,
    input wire logic reverse_start_input,
    output seq_bank_pkg::start_cmd_s start_cmd,
    output logic sequencer_active,
    output seq_bank_pkg::scale_e scale_mode,
    output logic [15:0] scale_value,
    output logic flash_clear_pulse,
    input wire logic [IN_TERMS-1:0] input_terminals,
    output logic [IN_TERMS-1:0] program_inputs,
    input wire logic [OUT_TERMS-1:0] drive_status_outputs,
    input wire logic [OUT_TERMS-1:0] program_outputs,
    input wire logic [OUT_TERMS-1:0] program_output_select,
    output logic [OUT_TERMS-1:0] output_terminals,
    input wire logic [3:0] program_word_index,
    output logic [15:0] program_word_rdata,
    input wire logic program_word_we,
    input wire logic [15:0] program_word_wdata
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    if (USER_WORDS < 1 || USER_WORDS > 16)
    begin : g_chk_words
        $error("USER_WORDS must be 1 to 16");
    end
    if (IN_TERMS < 1 || OUT_TERMS < 1)
    begin : g_chk_terms
        $error("Terminal counts must be positive");
    end

    // ****************************************
    // Bus address phase capture
    // ****************************************
    seq_bank_pkg::ahb_req_s req_q;
    seq_bank_pkg::ahb_req_s req_d;
    wire logic addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
    assign req_d.addr = haddr;
    assign req_d.write = hwrite;
    assign req_d.valid = addr_phase;

    // Zero wait states, so one flop holds the pending data phase
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            req_q <= '0;
        else
            req_q <= req_d;
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************
    // Decoding
    // ****************************************
    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        hit = (a[`OFS_ADDR_W-1:0] == ofs) && (a[31:`OFS_ADDR_W] == '0);
    endfunction

    function automatic logic user_hit(input logic [31:0] a, input int idx);
        logic [7:0] ofs;
        ofs = 8'(`OFS_USER_BASE + 4 * idx);
        user_hit = hit(a, ofs);
    endfunction

    wire logic wr = req_q.valid && req_q.write;
    wire logic wr_enable = wr && hit(req_q.addr, `OFS_ENABLE);
    wire logic wr_lock = wr && hit(req_q.addr, `OFS_RUN_LOCK);
    wire logic wr_ssel = wr && hit(req_q.addr, `OFS_SCALE_SEL);
    wire logic wr_sval = wr && hit(req_q.addr, `OFS_SCALE_VAL);
    wire logic wr_fclr = wr && hit(req_q.addr, `OFS_FLASH_CLR);
    wire logic [15:0] wdata = hwdata[15:0];

    // ****************************************
    // Configuration registers
    // ****************************************
    // Power-on value only; a drive reset must not wipe it or a new setting could never take effect
    logic [15:0] enable_sel_q = `RST_ENABLE;
    logic [15:0] run_lock_q;
    logic [15:0] scale_sel_q;
    logic [15:0] scale_val_q;
    logic [15:0] flash_clr_q;
    logic active_q;

    // Out-of-range writes are dropped so the stored value stays legal
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            run_lock_q <= `RST_RUN_LOCK;
            scale_sel_q <= `RST_SCALE_SEL;
            scale_val_q <= `RST_SCALE_VAL;
            flash_clr_q <= `RST_FLASH_CLR;
        end
        else
        begin
            if (wr_lock && wdata <= 16'h0001)
                run_lock_q <= wdata;
            if (wr_ssel && wdata <= `MAX_SCALE_SEL)
                scale_sel_q <= wdata;
            if (wr_sval && wdata <= `MAX_SCALE_VAL)
                scale_val_q <= wdata;
            if (wr_fclr && wdata <= `MAX_FLASH_CLR)
                flash_clr_q <= wdata;
        end
    end

    // Enable selection survives drive reset, so it is read at the next release
    always_ff @(posedge clock)
    begin
        if (wr_enable && wdata <= 16'h0001)
            enable_sel_q <= wdata;
    end

    // Enable selection sampled only just after reset release
    logic armed_q;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            armed_q <= 1'b1;
            active_q <= 1'b0;
        end
        else if (armed_q)
        begin
            armed_q <= 1'b0;
            active_q <= enable_sel_q[0];
        end
    end
    assign sequencer_active = active_q;

    // ****************************************
    // Flash clear pulse
    // ****************************************
    // Fires on the write itself, not on the stored level
    logic fclr_q;
    wire logic fclr_d = wr_fclr && (wdata == `FLASH_CLR_KEY);
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            fclr_q <= 1'b0;
        else
            fclr_q <= fclr_d;
    end
    assign flash_clear_pulse = fclr_q;

    // ****************************************
    // Pre-scale outputs
    // ****************************************
    always_comb
    begin
        case (scale_sel_q[2:0])
            3'h1: scale_mode = seq_bank_pkg::scale_x1;
            3'h2: scale_mode = seq_bank_pkg::scale_x0p1;
            3'h3: scale_mode = seq_bank_pkg::scale_x0p01;
            3'h4: scale_mode = seq_bank_pkg::scale_x0p001;
            3'h5: scale_mode = seq_bank_pkg::scale_x0p0001;
            default: scale_mode = seq_bank_pkg::scale_off;
        endcase
    end
    assign scale_value = scale_val_q;

    // ****************************************
    // Start gating
    // ****************************************
    logic key_run_q;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            key_run_q <= 1'b0;
        else
            key_run_q <= program_key_run;
    end
    wire logic lock_on = run_lock_q[0];
    wire logic start_ok = !lock_on || program_key_run;
    wire logic key_to_stop = key_run_q && !program_key_run;
    assign start_cmd.forward_start = forward_start_input && start_ok;
    assign start_cmd.reverse_start = reverse_start_input && start_ok;
    // Held while stopped so a running motor keeps decelerating
    assign start_cmd.decel_stop = lock_on && !program_key_run && (motor_running || key_to_stop);

    // ****************************************
    // Shared user words
    // ****************************************
    logic [15:0] user_q [USER_WORDS];
    genvar gi;
    generate
        for (gi = 0; gi < USER_WORDS; gi++)
        begin : g_user
            wire logic bus_we = wr && user_hit(req_q.addr, gi);
            wire logic prg_we = program_word_we && (32'(program_word_index) == gi);
            // Bus write wins when both sides write the same cycle
            always_ff @(posedge clock or posedge reset)
            begin
                if (reset)
                    user_q[gi] <= `RST_USER;
                else if (bus_we)
                    user_q[gi] <= wdata;
                else if (prg_we)
                    user_q[gi] <= program_word_wdata;
            end
        end
    endgenerate

    always_comb
    begin
        program_word_rdata = 16'h0000;
        for (int i = 0; i < USER_WORDS; i++)
            if (32'(program_word_index) == i)
                program_word_rdata = user_q[i];
    end

    // ****************************************
    // Terminals
    // ****************************************
    assign program_inputs = active_q ? input_terminals : '0;
    wire logic [OUT_TERMS-1:0] prog_sel = active_q ? program_output_select : '0;
    assign output_terminals = (prog_sel & program_outputs) | (~prog_sel & drive_status_outputs);

    // ****************************************
    // Read data
    // ****************************************
    logic [15:0] rd_user;
    always_comb
    begin
        rd_user = 16'h0000;
        for (int i = 0; i < USER_WORDS; i++)
            if (user_hit(req_q.addr, i))
                rd_user = user_q[i];
    end

    // Unmapped reads return zero
    wire logic [15:0] rd_word =
        hit(req_q.addr, `OFS_ENABLE) ? enable_sel_q :
        hit(req_q.addr, `OFS_RUN_LOCK) ? run_lock_q :
        hit(req_q.addr, `OFS_SCALE_SEL) ? scale_sel_q :
        hit(req_q.addr, `OFS_SCALE_VAL) ? scale_val_q :
        hit(req_q.addr, `OFS_FLASH_CLR) ? flash_clr_q :
        hit(req_q.addr, `OFS_STATUS) ? {13'h0000, motor_running, key_run_q, active_q} :
        rd_user;
    assign hrdata = (req_q.valid && !req_q.write) ? {16'h0000, rd_word} : 32'h0000_0000;
endmodule
`default_nettype wire

// ### test/seq_bank_checker.sv
// Purpose: Port assertions for the sequencer parameter bank
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound from the bench top file
`include "seq_bank_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module seq_bank_checker
#(
    parameter int IN_TERMS = 12,
    parameter int OUT_TERMS = 8
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic program_key_run,
    input wire logic forward_start_input,
    input wire seq_bank_pkg::start_cmd_s start_cmd,
    input wire logic sequencer_active,
    input wire seq_bank_pkg::scale_e scale_mode,
    input wire logic [15:0] scale_value,
    input wire logic flash_clear_pulse,
    input wire logic [IN_TERMS-1:0] input_terminals,
    input wire logic [IN_TERMS-1:0] program_inputs,
    input wire logic [OUT_TERMS-1:0] drive_status_outputs,
    input wire logic [OUT_TERMS-1:0] program_outputs,
    input wire logic [OUT_TERMS-1:0] program_output_select,
    input wire logic [OUT_TERMS-1:0] output_terminals
);
    // ****************
    // Checks
    // ****************
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Bits the program owns right now
    wire [OUT_TERMS-1:0] own = program_output_select & {OUT_TERMS{sequencer_active}};
    property p_frozen; !$past(reset) && !$past(reset, 2) |-> $stable(sequencer_active); endproperty
    a_frozen: assert property (p_frozen) else $error("active changed");
    property p_run; program_key_run |-> start_cmd.forward_start == forward_start_input; endproperty
    a_run: assert property (p_run) else $error("start lost");
    property p_idle; !forward_start_input |-> !start_cmd.forward_start; endproperty
    a_idle: assert property (p_idle) else $error("phantom start");
    property p_decel;
        start_cmd.decel_stop |-> !program_key_run && !start_cmd.forward_start && !start_cmd.reverse_start;
    endproperty
    a_decel: assert property (p_decel) else $error("decel with start");
    property p_mode; scale_mode <= seq_bank_pkg::scale_x0p0001; endproperty
    a_mode: assert property (p_mode) else $error("bad scale mode");
    property p_val; scale_value <= `MAX_SCALE_VAL; endproperty
    a_val: assert property (p_val) else $error("scale value range");
    property p_key; flash_clear_pulse |-> $past(hwdata[15:0]) == `FLASH_CLR_KEY; endproperty
    a_key: assert property (p_key) else $error("clear without key");
    property p_once; flash_clear_pulse |=> !flash_clear_pulse; endproperty
    a_once: assert property (p_once) else $error("clear repeated");
    property p_in; program_inputs == (sequencer_active ? input_terminals : '0); endproperty
    a_in: assert property (p_in) else $error("inputs not passed");
    property p_out;
        output_terminals == ((program_outputs & own) | (drive_status_outputs & ~own));
    endproperty
    a_out: assert property (p_out) else $error("output mix");
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus not okay");
    c_clear: cover property (flash_clear_pulse);
    c_decel: cover property (start_cmd.decel_stop);
    c_start: cover property (start_cmd.forward_start && sequencer_active);
endmodule
`default_nettype wire

// ### test/seq_program_model.sv
// Purpose: Terminals and sequence program beside the bank
// Assumes: Program port writes land on the next edge
// Notes: Released write data shows its inverse
`timescale 1ns/10ps
`default_nettype none
module seq_program_model
(
    input wire logic clock,
    output logic [11:0] input_terminals,
    output logic [7:0] drive_status_outputs,
    output logic [7:0] program_outputs,
    output logic [7:0] program_output_select,
    output logic [3:0] program_word_index,
    output logic program_word_we,
    output logic [15:0] program_word_wdata,
    input wire logic [15:0] program_word_rdata
);
    // Quiet terminals until told otherwise
    initial
    begin
        {input_terminals, drive_status_outputs, program_outputs, program_output_select} = '0;
        {program_word_index, program_word_we, program_word_wdata} = '0;
    end
    // Program stores into a shared word
    task automatic put(input logic [3:0] i, input logic [15:0] d);
        @(posedge clock);
        program_word_index <= i;
        program_word_wdata <= d;
        program_word_we <= 1'b1;
        @(posedge clock);
        program_word_we <= 1'b0;
        program_word_wdata <= ~d; // Stale data never looks valid
    endtask
    // Program loads a shared word
    task automatic get(input logic [3:0] i, output logic [15:0] d);
        @(posedge clock);
        program_word_index <= i;
        @(posedge clock);
        #1 d = program_word_rdata;
    endtask
    task automatic terms(input logic [11:0] t, input logic [7:0] o, input logic [7:0] s, input logic [7:0] st);
        input_terminals <= t;
        program_outputs <= o;
        program_output_select <= s;
        drive_status_outputs <= st;
    endtask
endmodule
`default_nettype wire

// ### test/embedded_sequencer_param_bank_bench.sv
// Purpose: Self-checking bench for the sequencer parameter bank
// Assumes: Enable setting survives a drive reset
// Notes: Single AHB-Lite word transfers only
`include "seq_bank_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module embedded_sequencer_param_bank_bench;
    logic clock = 0, reset = 1, hsel = 0, hwrite = 0, program_key_run = 0, motor_running = 0;
    logic forward_start_input = 0, reverse_start_input = 0, hreadyout, hresp, sequencer_active;
    logic flash_clear_pulse, program_word_we;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [15:0] scale_value, program_word_wdata, program_word_rdata;
    logic [11:0] input_terminals, program_inputs;
    logic [7:0] drive_status_outputs, program_outputs, program_output_select, output_terminals;
    logic [3:0] program_word_index;
    seq_bank_pkg::start_cmd_s start_cmd;
    seq_bank_pkg::scale_e scale_mode;
    int n_tests = 0, n_mismatch = 0;
    wire hready = hreadyout; // Single slave drives the bus ready
    embedded_sequencer_param_bank dut (.*);
    seq_program_model prog (.*);
    initial
    begin
        forever #25 clock = ~clock;
    end
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************
    // Bus and reset
    // ****************
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] wd, output logic [31:0] rd);
        int k;
        @(posedge clock);
        {hsel, hwrite, haddr, htrans, hsize} <= {1'b1, w, 24'h0, a, `HTRANS_NONSEQ, `HSIZE_WORD};
        k = 0;
        do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 16);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, 16'h0, wd};
        do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 16);
        rd = hrdata; // Taken at the closing edge
        if (k >= 16)
        begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        #1;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] r;
        bus(1'b0, a, 16'h0, r);
        `CHK(r, {16'h0, e})
    endtask
    task automatic do_reset;
        reset <= 1'b1;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        chk_rd(`OFS_ENABLE, `RST_ENABLE);
        chk_rd(`OFS_RUN_LOCK, `RST_RUN_LOCK);
        chk_rd(`OFS_SCALE_SEL, `RST_SCALE_SEL);
        chk_rd(`OFS_SCALE_VAL, `RST_SCALE_VAL);
        chk_rd(`OFS_FLASH_CLR, `RST_FLASH_CLR);
        chk_rd(8'h80, 16'h0); // Unmapped place reads zero
    endtask
    task automatic t_lock;
        {forward_start_input, reverse_start_input} <= 2'b11;
        wr(`OFS_RUN_LOCK, 16'h0);
        `CHK(start_cmd, 3'b110)
        wr(`OFS_RUN_LOCK, 16'h1);
        `CHK(start_cmd, 3'b000)
        {program_key_run, motor_running} <= 2'b11;
        #50 `CHK(start_cmd, 3'b110)
        program_key_run <= 1'b0;
        #50 `CHK(start_cmd.decel_stop, 1'b1)
        wr(`OFS_RUN_LOCK, 16'h2);
        chk_rd(`OFS_RUN_LOCK, 16'h1);
        {motor_running, forward_start_input, reverse_start_input} <= 3'b000;
    endtask
    task automatic t_scale;
        for (int i = 0; i < 6; i++)
        begin
            wr(`OFS_SCALE_SEL, i[15:0]);
            `CHK(scale_mode, seq_bank_pkg::scale_e'(i[2:0]))
        end
        wr(`OFS_SCALE_SEL, 16'h6);
        `CHK(scale_mode, seq_bank_pkg::scale_x0p0001)
        wr(`OFS_SCALE_VAL, `MAX_SCALE_VAL);
        `CHK(scale_value, 16'h7fff)
        wr(`OFS_SCALE_VAL, 16'h8000);
        `CHK(scale_value, 16'h7fff)
        wr(`OFS_SCALE_VAL, 16'h0);
        `CHK(scale_value, 16'h0)
    endtask
    task automatic t_flash;
        wr(`OFS_FLASH_CLR, 16'h25df);
        `CHK(flash_clear_pulse, 1'b0)
        wr(`OFS_FLASH_CLR, 16'h25e0);
        `CHK(flash_clear_pulse, 1'b1)
        repeat (4) #50 `CHK(flash_clear_pulse, 1'b0)
        chk_rd(`OFS_FLASH_CLR, 16'h25e0);
    endtask
    task automatic t_user;
        logic [15:0] r;
        for (int i = 0; i < 10; i++)
        begin
            chk_rd(`OFS_USER_BASE + 8'(4 * i), `RST_USER);
            wr(`OFS_USER_BASE + 8'(4 * i), 16'h1000 + 16'(i));
            prog.get(i[3:0], r);
            `CHK(r, 16'h1000 + 16'(i))
            prog.put(i[3:0], 16'hb000 + 16'(i));
            chk_rd(`OFS_USER_BASE + 8'(4 * i), 16'hb000 + 16'(i));
        end
    endtask
    task automatic t_terms;
        prog.terms(12'ha5c, 8'h3c, 8'h0f, 8'hc3);
        wr(`OFS_ENABLE, 16'h1);
        `CHK(sequencer_active, 1'b0)
        `CHK(program_inputs, 12'h0)
        `CHK(output_terminals, 8'hc3)
        do_reset();
        `CHK(sequencer_active, 1'b1)
        `CHK(program_inputs, 12'ha5c)
        `CHK(output_terminals, 8'hcc)
    endtask
    // Main sequence, terminal check last as it resets
    initial
    begin
        do_reset();
        t_reset();
        t_lock();
        t_scale();
        t_flash();
        t_user();
        t_terms();
        conclude();
    end
endmodule
bind embedded_sequencer_param_bank seq_bank_checker #(.IN_TERMS(IN_TERMS), .OUT_TERMS(OUT_TERMS)) chk (.*);
`default_nettype wire
